// file: sc1_tx_pkg.sv
// constants for the sc1 maintenance transmit selector
`default_nettype none
package sc1_tx_pkg;
   localparam int         CODE_W        = 4;
   localparam int         FIFO_DEPTH    = 2;
   localparam int         MF_PERIOD_MS  = 5;
   localparam int         TICK_MS       = 30;
   localparam int         MF_PER_TICK   = TICK_MS / MF_PERIOD_MS;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_LOW_TX    = 8'h04;
   localparam logic [7:0] OFS_HIGH_TX   = 8'h08;
   localparam logic [7:0] OFS_TX_STAT   = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN    = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR   = 8'h18;
   // field positions
   localparam int         BIT_TICK_EN   = 0;
   localparam int         BIT_IRQ_TICK  = 0;
   localparam int         BIT_IRQ_RXERR = 1;
   localparam int         IRQ_W         = 2;
   // reset values
   localparam logic [3:0] RST_CODE      = 4'h0;
   localparam logic [1:0] RST_IRQ       = 2'h0;
endpackage : sc1_tx_pkg
`default_nettype wire

// file: sc1_maintenance_msg_tx_select.sv
// sc1 transmit selector: low-priority register, two-entry high-priority fifo, tick irq
//
// Functional notes
// R01: tick interrupt every 30 ms once enabled
// R02: high queue holds two, each sent one multiframe
// R03: two fifo entries, four bits each
// R04: boundary sends fifo head, else low register
// R05: write to full fifo shifts, new at tail
// R06: code violation raises received multiframe error flag
// R07: firmware ranks repeating low messages, six frames
// R08: firmware ranks one-shot high messages
// R09: firmware writes highest low flag each tick
// R10: firmware queues dtse and fecv at once
// R11: firmware may write lp to both
// R12: firmware extends low message after high write
//
// The register addresses and the APB register port were left to the implementer.
`default_nettype none
module sc1_maintenance_msg_tx_select
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      mf_boundary,
   input  wire logic                      code_violation,
   output logic      [sc1_tx_pkg::CODE_W-1:0] sc1_tx_code,
   output logic                           sc1_tx_from_fifo,
   output logic                           irq
);
   import sc1_tx_pkg::*;

   // the fifo, code and tick counter widths below are fixed
   if (FIFO_DEPTH != 2 || CODE_W != 4 || MF_PER_TICK < 1 || MF_PER_TICK > 8) begin : g_cfg_check
      $error("unsupported fifo depth, code width or tick count");
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detect
   logic [2:0] mf_sync_r;
   logic [2:0] cv_sync_r;
   logic       mf_edge;
   logic       cv_pulse;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mf_sync_r <= 3'h0;
         cv_sync_r <= 3'h0;
      end else begin
         mf_sync_r <= {mf_sync_r[1:0], mf_boundary};
         cv_sync_r <= {cv_sync_r[1:0], code_violation};
      end
   end
   assign mf_edge  = mf_sync_r[1] & ~mf_sync_r[2];
   assign cv_pulse = cv_sync_r[1] & ~cv_sync_r[2];

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic acc;
   logic wr;
   logic mapped;
   assign acc    = psel & penable;
   assign wr     = acc & pwrite;
   assign mapped = hit(paddr, OFS_CTRL) | hit(paddr, OFS_LOW_TX) | hit(paddr, OFS_HIGH_TX)
                 | hit(paddr, OFS_TX_STAT) | hit(paddr, OFS_IRQ_STAT)
                 | hit(paddr, OFS_IRQ_EN) | hit(paddr, OFS_IRQ_CLR);
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   ////////////////////////////////////////////////////////////////////////
   // state
   logic             tick_en_r,  tick_en_nxt;
   logic [3:0]       low_r,      low_nxt;
   logic [3:0]       e0_r,       e0_nxt;
   logic [3:0]       e1_r,       e1_nxt;
   logic [1:0]       cnt_r,      cnt_nxt;
   logic [2:0]       mf_cnt_r,   mf_cnt_nxt;
   logic [3:0]       tx_r,       tx_nxt;
   logic             from_r,     from_nxt;
   logic [IRQ_W-1:0] stat_r,     stat_nxt;
   logic [IRQ_W-1:0] en_r,       en_nxt;
   logic             push;
   logic             pop;
   logic             tick_pulse;

   assign push       = wr & hit(paddr, OFS_HIGH_TX);
   assign pop        = mf_edge & (cnt_r != 2'd0);
   assign tick_pulse = tick_en_r & mf_edge & (mf_cnt_r == 3'(MF_PER_TICK - 1));

   always_comb begin
      tick_en_nxt = tick_en_r;
      low_nxt     = low_r;
      en_nxt      = en_r;
      mf_cnt_nxt  = mf_cnt_r;
      tx_nxt      = tx_r;
      from_nxt    = from_r;
      e0_nxt      = e0_r;
      e1_nxt      = e1_r;
      cnt_nxt     = cnt_r;
      stat_nxt    = stat_r;
      if (wr && hit(paddr, OFS_CTRL)) begin
         tick_en_nxt = pwdata[BIT_TICK_EN];
      end
      if (wr && hit(paddr, OFS_LOW_TX)) begin
         low_nxt = pwdata[CODE_W-1:0];
      end
      if (wr && hit(paddr, OFS_IRQ_EN)) begin
         en_nxt = pwdata[IRQ_W-1:0];
      end
      // multiframe counter for the 30 ms tick
      if (!tick_en_r) begin
         mf_cnt_nxt = 3'h0;
      end else if (mf_edge) begin
         mf_cnt_nxt = tick_pulse ? 3'h0 : mf_cnt_r + 3'h1; // R01
      end
      // boundary selection
      if (mf_edge) begin
         tx_nxt   = pop ? e0_r : low_r; // R04
         from_nxt = pop;
      end
      if (pop) begin
         e0_nxt  = e1_r; // R02
         cnt_nxt = cnt_r - 2'd1;
      end
      if (push) begin
         case (cnt_nxt)
            2'd0:    begin
               e0_nxt  = pwdata[CODE_W-1:0]; // R03
               cnt_nxt = 2'd1;
            end
            2'd1:    begin
               e1_nxt  = pwdata[CODE_W-1:0]; // R03
               cnt_nxt = 2'd2;
            end
            default: begin
               e0_nxt  = e1_nxt; // R05
               e1_nxt  = pwdata[CODE_W-1:0];
               cnt_nxt = 2'd2;
            end
         endcase
      end
      // sticky flags: clear first, set wins
      if (wr && hit(paddr, OFS_IRQ_CLR)) begin
         stat_nxt = stat_nxt & ~pwdata[IRQ_W-1:0];
      end
      if (tick_pulse) begin
         stat_nxt[BIT_IRQ_TICK] = 1'b1; // R01
      end
      if (cv_pulse) begin
         stat_nxt[BIT_IRQ_RXERR] = 1'b1; // R06
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_en_r <= 1'b0;
         low_r     <= RST_CODE;
         en_r      <= RST_IRQ;
         mf_cnt_r  <= 3'h0;
         tx_r      <= RST_CODE;
         from_r    <= 1'b0;
         e0_r      <= RST_CODE;
         e1_r      <= RST_CODE;
         cnt_r     <= 2'd0;
         stat_r    <= RST_IRQ;
      end else begin
         tick_en_r <= tick_en_nxt;
         low_r     <= low_nxt;
         en_r      <= en_nxt;
         mf_cnt_r  <= mf_cnt_nxt;
         tx_r      <= tx_nxt;
         from_r    <= from_nxt;
         e0_r      <= e0_nxt;
         e1_r      <= e1_nxt;
         cnt_r     <= cnt_nxt;
         stat_r    <= stat_nxt;
      end
   end

   assign sc1_tx_code      = tx_r;
   assign sc1_tx_from_fifo = from_r;
   assign irq              = |(stat_r & en_r);

   ////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup phase
   logic [31:0] rd_r, rd_nxt;

   always_comb begin
      rd_nxt = rd_r;
      if (psel && !penable) begin
         rd_nxt = 32'h0000_0000;
         if (hit(paddr, OFS_CTRL))     rd_nxt[BIT_TICK_EN] = tick_en_r;
         if (hit(paddr, OFS_LOW_TX))   rd_nxt[3:0] = low_r;
         if (hit(paddr, OFS_HIGH_TX))  rd_nxt[1:0] = cnt_r;
         if (hit(paddr, OFS_TX_STAT))  rd_nxt[7:0] = {2'b00, cnt_r, tx_r};
         if (hit(paddr, OFS_IRQ_STAT)) rd_nxt[IRQ_W-1:0] = stat_r;
         if (hit(paddr, OFS_IRQ_EN))   rd_nxt[IRQ_W-1:0] = en_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_r <= 32'h0000_0000;
      end else begin
         rd_r <= rd_nxt;
      end
   end
   assign prdata = rd_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_tick_rate: assert property (@(posedge pclk) disable iff (!presetn)
      stat_r[BIT_IRQ_TICK] && !$past(stat_r[BIT_IRQ_TICK]) |->
      $past(tick_en_r) && $past(mf_edge) && $past(mf_cnt_r) == 3'(MF_PER_TICK - 1))
      else $error("tick flag without six multiframes"); // R01
   a_head_once: assert property (@(posedge pclk) disable iff (!presetn)
      pop && !push |=> cnt_r == $past(cnt_r) - 2'd1 && from_r)
      else $error("queued code not consumed in one multiframe"); // R02
   a_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_r <= 2'(FIFO_DEPTH))
      else $error("fifo count above depth"); // R03
   a_boundary_select: assert property (@(posedge pclk) disable iff (!presetn)
      mf_edge |=> tx_r == ($past(cnt_r) != 2'd0 ? $past(e0_r) : $past(low_r)))
      else $error("wrong code chosen at boundary"); // R04
   a_full_shift: assert property (@(posedge pclk) disable iff (!presetn)
      push && !mf_edge && cnt_r == 2'd2 |=>
      e0_r == $past(e1_r) && e1_r == $past(pwdata[3:0]) && cnt_r == 2'd2)
      else $error("overwrite of full fifo wrong"); // R05
   a_err_flag: assert property (@(posedge pclk) disable iff (!presetn)
      cv_pulse |=> stat_r[BIT_IRQ_RXERR] ##1
      (stat_r[BIT_IRQ_RXERR] || $past(wr && hit(paddr, OFS_IRQ_CLR) && pwdata[BIT_IRQ_RXERR])))
      else $error("code violation flag not held"); // R06
endmodule : sc1_maintenance_msg_tx_select
`default_nettype wire

// file: sc1_line_partner.sv
// line-side partner: drives boundary and violation pins
`default_nettype none
module sc1_line_partner (
   input  wire logic pclk,
   output logic      mf_boundary,
   output logic      code_violation
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      mf_boundary    = 1'b0;
      code_violation = 1'b0;
   end
   // one rising edge per call, then settle time
   task pulse(input logic viol);
      @(posedge pclk);
      if (viol) code_violation <= 1'b1;
      else mf_boundary <= 1'b1;
      repeat (4) @(posedge pclk);
      code_violation <= 1'b0;
      mf_boundary    <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask : pulse
endmodule : sc1_line_partner
`default_nettype wire

// file: sc1_maintenance_msg_tx_select_test.sv
// bench for the sc1 transmit selector
`default_nettype none
module sc1_maintenance_msg_tx_select_test;
   import sc1_tx_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        mf_boundary, code_violation, from_fifo, irq, e;
   logic [3:0]  tx_code;
   int          err_count, comparisons;
   sc1_maintenance_msg_tx_select u_sc1_maintenance_msg_tx_select (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mf_boundary(mf_boundary), .code_violation(code_violation),
      .sc1_tx_code(tx_code), .sc1_tx_from_fifo(from_fifo), .irq(irq));
   sc1_line_partner u_sc1_line_partner (.pclk(pclk), .mf_boundary(mf_boundary),
      .code_violation(code_violation));
   ////////////////////////////////////////////////////////////////////////////
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : xfer
   task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(name, exp, q);
   endtask : rd
   task line(input logic [3:0] code, input logic ff);
      u_sc1_line_partner.pulse(1'b0);
      chk("tx_code", {28'h0, code}, {28'h0, tx_code});
      chk("from_fifo", {31'h0, ff}, {31'h0, from_fifo});
   endtask : line
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      final_report();
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; err_count = 0; comparisons = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl", OFS_CTRL, 32'h0);
      chk("pslverr", 32'h0, {31'h0, e});
      chk("pready", 32'h1, {31'h0, pready});
      rd("irq_stat", OFS_IRQ_STAT, 32'h0);
      xfer(1'b1, OFS_LOW_TX, 32'h5);
      line(4'h5, 1'b0);
      xfer(1'b1, OFS_HIGH_TX, 32'hA);
      xfer(1'b1, OFS_HIGH_TX, 32'hB);
      xfer(1'b1, OFS_LOW_TX, 32'h5);
      rd("fifo_count", OFS_HIGH_TX, 32'h2);
      xfer(1'b1, OFS_HIGH_TX, 32'hC);
      rd("fifo_count", OFS_HIGH_TX, 32'h2);
      line(4'hB, 1'b1);
      line(4'hC, 1'b1);
      rd("tx_stat", OFS_TX_STAT, 32'hC);
      line(4'h5, 1'b0);
      xfer(1'b0, 8'h1C, 32'h0);
      chk("pslverr", 32'h1, {31'h0, e});
      xfer(1'b1, OFS_IRQ_EN, 32'h1);
      xfer(1'b1, OFS_CTRL, 32'h1);
      rd("ctrl", OFS_CTRL, 32'h1);
      repeat (5) line(4'h5, 1'b0);
      rd("irq_stat", OFS_IRQ_STAT, 32'h0);
      line(4'h5, 1'b0);
      rd("irq_stat", OFS_IRQ_STAT, 32'h1);
      chk("irq", 32'h1, {31'h0, irq});
      xfer(1'b1, OFS_IRQ_CLR, 32'h1);
      @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      xfer(1'b1, OFS_CTRL, 32'h0);
      u_sc1_line_partner.pulse(1'b1);
      rd("irq_stat", OFS_IRQ_STAT, 32'h2);
      chk("irq", 32'h0, {31'h0, irq});
      xfer(1'b1, OFS_IRQ_EN, 32'h3);
      @(posedge pclk);
      chk("irq", 32'h1, {31'h0, irq});
      rd("irq_en", OFS_IRQ_EN, 32'h3);
      xfer(1'b1, OFS_IRQ_CLR, 32'h3);
      rd("irq_stat", OFS_IRQ_STAT, 32'h0);
      rd("low_tx", OFS_LOW_TX, 32'h5);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("tx_code", {28'h0, RST_CODE}, {28'h0, tx_code});
      presetn <= 1'b1;
      rd("low_tx", OFS_LOW_TX, 32'h0);
      rd("irq_en", OFS_IRQ_EN, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      final_report();
   end
endmodule : sc1_maintenance_msg_tx_select_test
`default_nettype wire
